// ---- rxmp_pkg.sv ----
package rxmp_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 5;
    localparam int NUM_CH = 4;
    localparam int FIFO_DEPTH = 8;
    localparam logic [4:0] NULL_PORT = 5'h1F;
    // Base of this device's four ports in the shared address space
    localparam logic [4:0] PORT_BASE_DEF = 5'h00;
    localparam int WORDS_PER_CELL = 27;
    localparam logic [4:0] CELL_LAST_IDX = 5'h1A;

    typedef struct packed {
        logic [15:0] word;
        logic cellStart;
    } rxmp_word_s;

    typedef struct packed {
        logic [15:0] bus;
        logic parity;
        logic cellStart;
        logic valid;
    } rxmp_out_s;
endpackage

// ---- rxmp_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module rxmp_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wrPtr_ff;
    logic [AW-1:0] rdPtr_ff;
    logic [AW:0] count_ff;
    logic doWr;
    logic doRd;

    assign inReady = (count_ff != (AW+1)'(DEPTH));
    assign outValid = (count_ff != '0);
    assign outData = mem_ff[rdPtr_ff];
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;

    always_ff @(posedge clk) begin
        if (doWr) begin
            mem_ff[wrPtr_ff] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (doWr) begin
                wrPtr_ff <= AW'((wrPtr_ff + 1'b1) % DEPTH);
            end
            if (doRd) begin
                rdPtr_ff <= AW'((rdPtr_ff + 1'b1) % DEPTH);
            end
            count_ff <= count_ff + (AW+1)'(doWr) - (AW+1)'(doRd);
        end
    end
endmodule
`default_nettype wire

// ---- rxmp_output_bus.sv ----
// How it works
// - Cell mode: present selected FIFO's cell words
// - Float bus, parity and cell start while read enable high (word valid is always driven)
// - Float bus, parity and cell start for null or foreign port
// - Data bus changes only on clock rise
// - Packet mode: 16-bit words qualified by valid flag
// - Parity covers all sixteen data bits
// - Odd/even parity per channel sense bit
// - Parity changes on clock rise with data
// - Cell start marks first cell word
// - Cell start changes on clock rise
// - Enable high latches address; low reads
`timescale 1ns/10ps
`default_nettype none
module rxmp_output_bus (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Mode and per-channel parity sense (1 = odd)
    input wire logic cellMode,
    input wire logic [3:0] rxParitySense,
    input wire logic [4:0] portBase,
    // Channel word sources, one per receive FIFO
    input wire logic [3:0] chValid,
    output logic [3:0] chReady,
    input wire logic [63:0] chWord,
    input wire logic [3:0] chCellStart,
    // Link-side pins
    input wire logic rxReadEnableN,
    input wire logic [4:0] rxPortSelect,
    output logic [15:0] rxWordBus,
    output logic [15:0] rxWordBusOe,
    output logic rxWordParity,
    output logic rxWordParityOe,
    output logic rxCellStart,
    output logic rxCellStartOe,
    output logic rxWordValid
);
    function automatic logic parityOf(input logic [15:0] w, input logic odd);
        parityOf = (^w) ^ odd;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic rdEnNMeta_ff, rdEnNSync_ff;
    logic [4:0] adrMeta_ff, adrSync_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            rdEnNMeta_ff <= 1'b1;
            rdEnNSync_ff <= 1'b1;
            adrMeta_ff <= rxmp_pkg::NULL_PORT;
            adrSync_ff <= rxmp_pkg::NULL_PORT;
        end else begin
            rdEnNMeta_ff <= rxReadEnableN;
            rdEnNSync_ff <= rdEnNMeta_ff;
            adrMeta_ff <= rxPortSelect;
            adrSync_ff <= adrMeta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port latch: taken only while enable high
    logic [4:0] port_ff;
    logic portOk;
    logic [1:0] chIdx;
    logic [4:0] portOff;
    assign portOff = port_ff - portBase;
    assign portOk = (port_ff != rxmp_pkg::NULL_PORT) &&
                    (portOff < 5'h04);
    assign chIdx = portOff[1:0];
    always_ff @(posedge clk) begin
        if (rst) begin
            port_ff <= rxmp_pkg::NULL_PORT;
        end else if (rdEnNSync_ff) begin
            port_ff <= adrSync_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output FIFO: absorbs the channel word while the pins stall
    rxmp_pkg::rxmp_word_s inW, outW;
    logic inV, inR, outV, outR;
    assign inV = portOk && chValid[chIdx];
    assign inW.word = chWord[chIdx*16 +: 16];
    assign inW.cellStart = chCellStart[chIdx] && cellMode;
    always_comb begin
        chReady = 4'h0;
        chReady[chIdx] = portOk && inR;
    end
    // Read happens only when enable low and a local port is selected
    assign outR = !rdEnNSync_ff && portOk;
    rxmp_fifo #(.WIDTH(17), .DEPTH(rxmp_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .inValid(inV),
        .inReady(inR),
        .inData(inW),
        .outValid(outV),
        .outReady(outR),
        .outData(outW)
    );
    // Channel switch flushes nothing; words of the old port left in the FIFO
    // are presented first when the next local port is read.

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs, all updated on the same edge
    rxmp_pkg::rxmp_out_s out_ff;
    logic drive_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            out_ff <= '0;
        end else if (outR && outV) begin
            out_ff.bus <= outW.word;
            out_ff.parity <= parityOf(outW.word,
                rxParitySense[chIdx]);
            out_ff.cellStart <= outW.cellStart;
            out_ff.valid <= 1'b1;
        end else begin
            out_ff.valid <= 1'b0;
            out_ff.cellStart <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            drive_ff <= 1'b0;
        end else begin
            drive_ff <= !rdEnNSync_ff && portOk;
        end
    end

    assign rxWordBus = out_ff.bus;
    assign rxWordParity = out_ff.parity;
    assign rxCellStart = out_ff.cellStart;
    assign rxWordValid = out_ff.valid;
    assign rxWordBusOe = {16{drive_ff}};
    assign rxWordParityOe = drive_ff;
    assign rxCellStartOe = drive_ff;
endmodule
`default_nettype wire

// ---- rxmp_output_bus_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module rxmp_ob_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched ports
    input wire logic [3:0] rxParitySense,
    input wire logic rxReadEnableN,
    input wire logic [4:0] rxPortSelect,
    input wire logic [15:0] rxWordBus,
    input wire logic [15:0] rxWordBusOe,
    input wire logic rxWordParity,
    input wire logic rxWordParityOe,
    input wire logic rxCellStart,
    input wire logic rxCellStartOe,
    input wire logic rxWordValid
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
// Parity is only predictable here while all channels share one sense
wire sameSense = &rxParitySense || ~|rxParitySense;
sequence enIdle; rxReadEnableN [*4]; endsequence
sequence nullSel;
    (rxReadEnableN && rxPortSelect == rxmp_pkg::NULL_PORT) [*4];
endsequence
par_sense_a: assert property (rxWordValid && sameSense |->
    rxWordParity == (^rxWordBus ^ rxParitySense[0])) else $error("parity");
float_idle_a: assert property (enIdle |-> !rxWordBusOe)
    else $error("driven while idle");
null_float_a: assert property (nullSel ##1
    (rxPortSelect == rxmp_pkg::NULL_PORT) [*3] |-> !rxWordParityOe)
    else $error("driven for null port");
oe_together_a: assert property (rxWordBusOe == {16{rxWordParityOe}} &&
    rxCellStartOe == rxWordParityOe) else $error("enables differ");
start_word_a: assert property (rxCellStart |-> rxWordValid)
    else $error("start without word");
start_pulse_a: assert property (rxCellStart |=> !rxCellStart)
    else $error("start too long");
word_hold_a: assert property (!rxWordValid |->
    $stable({rxWordBus, rxWordParity})) else $error("bus moved");
valid_driven_a: assert property (rxWordValid |-> rxWordParityOe)
    else $error("word while floating");
endmodule
bind rxmp_output_bus rxmp_ob_chk i_rxmp_ob_chk (.clk, .rst, .rxParitySense,
    .rxReadEnableN, .rxPortSelect, .rxWordBus, .rxWordBusOe, .rxWordParity,
    .rxWordParityOe, .rxCellStart, .rxCellStartOe, .rxWordValid);
`default_nettype wire

// ---- rxmp_link_reader.sv ----
`timescale 1ns/10ps
`default_nettype none
module rxmp_link_reader (
    // Clock
    input wire logic clk,
    // Link pins
    output logic rxReadEnableN,
    output logic [4:0] rxPortSelect,
    input wire logic [15:0] rxWordBus,
    input wire logic rxCellStart,
    input wire logic rxWordValid
);
logic [16:0] got[$];
initial begin
    rxReadEnableN = 1'b1;
    rxPortSelect = rxmp_pkg::NULL_PORT;
end
// Bus content is taken only while valid is high
always @(posedge clk) if (rxWordValid) got.push_back({rxCellStart, rxWordBus});
// Select with enable high, then read n cycles
task automatic burst(input logic [4:0] port, input int n);
    got.delete();
    @(posedge clk);
    #1 rxPortSelect = port;
    repeat (4) @(posedge clk);
    #1 rxReadEnableN = 1'b0;
    repeat (n) @(posedge clk);
    #1 rxReadEnableN = 1'b1;
    repeat (6) @(posedge clk);
    #1;
endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
logic clk, rst, cellMode;
logic [3:0] sense, chValid, chReady, chStart;
logic [63:0] chWord;
logic [11:0] cnt[4];
logic rdN, par, parOe, soc, socOe, val;
logic [4:0] sel, base;
logic [15:0] bus, busOe;
int fails, checkCount;
rxmp_output_bus i_rxmp_output_bus (.clk, .rst, .cellMode,
    .rxParitySense(sense), .portBase(base), .chValid, .chReady, .chWord,
    .chCellStart(chStart), .rxReadEnableN(rdN), .rxPortSelect(sel),
    .rxWordBus(bus), .rxWordBusOe(busOe), .rxWordParity(par),
    .rxWordParityOe(parOe), .rxCellStart(soc), .rxCellStartOe(socOe),
    .rxWordValid(val));
rxmp_link_reader i_rxmp_link_reader (.clk, .rxReadEnableN(rdN),
    .rxPortSelect(sel), .rxWordBus(bus), .rxCellStart(soc), .rxWordValid(val));
// Channel n sends {n, sequence}; a new cell every 27 words
always_comb for (int n = 0; n < 4; n++) begin
    chWord[16*n +: 16] = {n[3:0], cnt[n]};
    chStart[n] = cnt[n] % rxmp_pkg::WORDS_PER_CELL == 0;
end
always @(posedge clk) for (int n = 0; n < 4; n++)
    cnt[n] <= rst ? 12'h000 : cnt[n] + 12'(chReady[n] & chValid[n]);
initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
        fails++;
        $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
endtask
task automatic cellTest();
    i_rxmp_link_reader.burst(5'h05, 40);
    check("word count", 1, i_rxmp_link_reader.got.size() >= 28);
    check("float", 0, busOe);
    foreach (i_rxmp_link_reader.got[i])
        check("cell word", {i % 27 == 0, 4'h1, 12'(i)}, i_rxmp_link_reader.got[i]);
    $display("cell test done");
endtask
task automatic refuseTest();
    logic [4:0] bad[3] = '{rxmp_pkg::NULL_PORT, 5'h03, 5'h08};
    foreach (bad[k]) begin
        i_rxmp_link_reader.burst(bad[k], 10);
        check("refused", 0, i_rxmp_link_reader.got.size());
        check("null float", 0, parOe);
    end
    $display("refuse test done");
endtask
task automatic packetTest();
    cellMode = 1'b0;
    sense = 4'h0;
    i_rxmp_link_reader.burst(5'h06, 40);
    check("word count", 1, i_rxmp_link_reader.got.size() >= 28);
    foreach (i_rxmp_link_reader.got[i])
        check("no start", 0, i_rxmp_link_reader.got[i][16]);
    check("channel", 4'h2, i_rxmp_link_reader.got[$][15:12]);
    $display("packet test done");
endtask
task automatic end_of_test();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
initial begin
    repeat (3000) @(posedge clk);
    fails++;
    end_of_test();
end
initial begin
    rst = 1'b1;
    cellMode = 1'b1;
    sense = 4'hF;
    base = 5'h04;
    chValid = 4'hF;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    cellTest();
    refuseTest();
    packetTest();
    end_of_test();
end
endmodule
`default_nettype wire
